// ==== shared/bsc_pkg.sv ====
// Function
// - host owns start, stop and direction; this block only answers as addressed client
// - data change while clock high is a bus condition, never a bit
// - data falling while clock high marks start
// - data rising while clock high marks stop
// - transmitter changes data only while clock low, one bit per pulse
// - receiver answers each byte with acknowledge on extra host pulse
// - acknowledger holds data low through whole high phase of pulse
// - host withholds last read acknowledge; device then releases data high
// - unprotected array write acknowledges control, both address bytes, every data
// - protected array write acknowledges control and addresses, refuses data byte
// - status write at 00h acknowledged, internal cycle done within 1 ms
// - command 55h: 33h store, ddh recall acknowledged, others refused
// - undefined register address refused, and any following data refused
// - control byte: four-bit op code, two select bits, zero, direction bit
// - array byte written at rising clock edge of its acknowledge bit
// - refused protected write stops without pointer advance, bus ignored until start
package bsc_pkg;

	localparam logic [3:0] BSC_OP_ARRAY = 4'ha;
	localparam logic [3:0] BSC_OP_REG = 4'h3;
	localparam logic [7:0] BSC_REG_STATUS = 8'h00;
	localparam logic [7:0] BSC_REG_CMD = 8'h55;
	localparam logic [7:0] BSC_CMD_STORE = 8'h33;
	localparam logic [7:0] BSC_CMD_RECALL = 8'hdd;
	localparam logic [7:0] BSC_STATUS_RST = 8'h00;
	// block-protect field position inside status
	localparam int BSC_BP_LSB = 2;
	localparam int BSC_BP_MSB = 4;
	localparam logic [3:0] BSC_ACK_BIT = 4'h8;
	localparam logic [3:0] BSC_LAST_BIT = 4'h7;
	// status write cycle time and its cycle count
	localparam int BSC_CLK_PERIOD_NS = 10;
	localparam int BSC_TWC_MS = 1;
	localparam int BSC_TWC_CYC = (BSC_TWC_MS * 1000000) / BSC_CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		BSC_CTRL = 3'b000,
		BSC_ADDR_HI = 3'b001,
		BSC_ADDR_LO = 3'b010,
		BSC_DATA_W = 3'b011,
		BSC_REG_ADDR = 3'b100,
		BSC_REG_DATA = 3'b101,
		BSC_READ = 3'b110,
		BSC_IGNORE = 3'b111
	} bsc_state_t;

endpackage

// ==== rtl/bsc_client.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsc_client
	import bsc_pkg::*;
#(
	parameter int AW = 9,
	parameter int TWC_CYC = BSC_TWC_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl_link,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic chip_select_pin_high,
	input wire logic chip_select_pin_low,
	output logic store_pulse,
	output logic recall_pulse,
	output logic status_busy,
	output logic bus_live
);

	localparam int DEPTH = 1 << AW;

	// ---------------- system clock side ----------------
	logic [2:0] scl_sh_r, scl_sh_nxt;
	logic [2:0] sda_sh_r, sda_sh_nxt;
	logic gen_r, gen_nxt;
	logic live_r, live_nxt;
	logic [2:0] st_sy_r, st_sy_nxt;
	logic [2:0] rc_sy_r, rc_sy_nxt;
	logic [2:0] wc_sy_r, wc_sy_nxt;
	logic [31:0] wc_cnt_r, wc_cnt_nxt;
	logic st_pl_r, st_pl_nxt;
	logic rc_pl_r, rc_pl_nxt;
	logic start_det;
	logic stop_det;

	// ---------------- link side, rising edge ----------------
	bsc_state_t lk_st_r, lk_st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic ack_r, ack_nxt;
	logic [AW-1:0] ptr_r, ptr_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [7:0] rsel_r, rsel_nxt;
	logic [7:0] stat_r, stat_nxt;
	logic rd_reg_r, rd_reg_nxt;
	logic seen_r, seen_nxt;
	logic store_tgl_r, store_tgl_nxt;
	logic recall_tgl_r, recall_tgl_nxt;
	logic wc_tgl_r, wc_tgl_nxt;
	logic [1:0] lrst_s_r;
	logic [1:0] csh_s_r;
	logic [1:0] csl_s_r;
	logic wr_en;
	logic [7:0] byte_in;
	logic [7:0] mem_q;
	logic [7:0] mem [DEPTH];

	// ---------------- link side, falling edge ----------------
	logic drv_r, drv_nxt;

	// open drain: the pin is only ever pulled low
	// client side only
	assign sda_out = 1'b0;
	assign bus_live = live_r;
	assign store_pulse = st_pl_r;
	assign recall_pulse = rc_pl_r;
	assign status_busy = (wc_cnt_r != 32'h0);

	// stage 3 is an old copy of stage 2, used only for edges
	// start detect
	assign start_det = scl_sh_r[1] & scl_sh_r[2] & sda_sh_r[2] & ~sda_sh_r[1];
	assign stop_det = scl_sh_r[1] & scl_sh_r[2] & ~sda_sh_r[2] & sda_sh_r[1];

	// the pin is let go as soon as a stop is seen
	// release after stop
	assign sda_oe = drv_r & live_r;

	// bus condition watch and event pulses on the system clock
	always_comb begin
		scl_sh_nxt = {scl_sh_r[1:0], scl_link};
		sda_sh_nxt = {sda_sh_r[1:0], sda_in};
		st_sy_nxt = {st_sy_r[1:0], store_tgl_r};
		rc_sy_nxt = {rc_sy_r[1:0], recall_tgl_r};
		wc_sy_nxt = {wc_sy_r[1:0], wc_tgl_r};
		gen_nxt = gen_r;
		live_nxt = live_r;
		wc_cnt_nxt = wc_cnt_r;
		if (start_det) begin
			gen_nxt = ~gen_r;
			live_nxt = 1'b1;
		end else if (stop_det) begin
			live_nxt = 1'b0;
		end
		st_pl_nxt = st_sy_r[2] ^ st_sy_r[1];
		rc_pl_nxt = rc_sy_r[2] ^ rc_sy_r[1];
		if (wc_sy_r[2] ^ wc_sy_r[1]) begin
			wc_cnt_nxt = 32'(TWC_CYC);
		end else if (wc_cnt_r != 32'h0) begin
			wc_cnt_nxt = wc_cnt_r - 32'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			scl_sh_r <= 3'h7;
			sda_sh_r <= 3'h7;
			gen_r <= 1'b0;
			live_r <= 1'b0;
			st_sy_r <= 3'h0;
			rc_sy_r <= 3'h0;
			wc_sy_r <= 3'h0;
			wc_cnt_r <= 32'h0;
			st_pl_r <= 1'b0;
			rc_pl_r <= 1'b0;
		end else begin
			scl_sh_r <= scl_sh_nxt;
			sda_sh_r <= sda_sh_nxt;
			gen_r <= gen_nxt;
			live_r <= live_nxt;
			st_sy_r <= st_sy_nxt;
			rc_sy_r <= rc_sy_nxt;
			wc_sy_r <= wc_sy_nxt;
			wc_cnt_r <= wc_cnt_nxt;
			st_pl_r <= st_pl_nxt;
			rc_pl_r <= rc_pl_nxt;
		end
	end

	assign byte_in = {sh_r[6:0], sda_in};
	assign mem_q = mem[ptr_r];

	// protection: field n guards the top 1/2^(7-n) of the array, except field 0 guards none
	function automatic logic is_prot(input logic [AW-1:0] a, input logic [7:0] st);
		logic [2:0] bp;
		logic [AW:0] lim;
		bp = st[BSC_BP_MSB:BSC_BP_LSB];
		lim = (AW+1)'(DEPTH) - ((AW+1)'(DEPTH) >> (3'h7 - bp));
		is_prot = (bp != 3'h0) && ({1'b0, a} >= lim);
	endfunction

	// bit shifting, acknowledge choice and ack-edge actions
	always_comb begin
		lk_st_nxt = lk_st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		ack_nxt = ack_r;
		ptr_nxt = ptr_r;
		tx_nxt = tx_r;
		rsel_nxt = rsel_r;
		stat_nxt = stat_r;
		rd_reg_nxt = rd_reg_r;
		seen_nxt = seen_r;
		store_tgl_nxt = store_tgl_r;
		recall_tgl_nxt = recall_tgl_r;
		wc_tgl_nxt = wc_tgl_r;
		wr_en = 1'b0;
		// gen_r only moves while scl is high after a start, so it is
		// steady by this edge; a new start restarts the frame here
		if (seen_r != gen_r) begin
			seen_nxt = gen_r;
			lk_st_nxt = BSC_CTRL;
			cnt_nxt = 4'h1;
			sh_nxt = {7'h0, sda_in};
			ack_nxt = 1'b0;
		end else if (cnt_r != BSC_ACK_BIT) begin
			sh_nxt = byte_in;
			cnt_nxt = cnt_r + 4'h1;
			if (cnt_r == BSC_LAST_BIT) begin
				case (lk_st_r)
					BSC_CTRL: begin
						ack_nxt = ((byte_in[7:4] == BSC_OP_ARRAY) || (byte_in[7:4] == BSC_OP_REG))
							&& (byte_in[3] == csh_s_r[1]) && (byte_in[2] == csl_s_r[1])
							&& !byte_in[1];
					end
					BSC_ADDR_HI, BSC_ADDR_LO: ack_nxt = 1'b1;
					BSC_DATA_W: ack_nxt = !is_prot(ptr_r, stat_r);
					BSC_REG_ADDR: ack_nxt = (byte_in == BSC_REG_STATUS) || (byte_in == BSC_REG_CMD);
					BSC_REG_DATA: begin
						ack_nxt = (rsel_r == BSC_REG_STATUS) || (byte_in == BSC_CMD_STORE)
							|| (byte_in == BSC_CMD_RECALL);
					end
					default: ack_nxt = 1'b0;
				endcase
			end
		end else begin
			cnt_nxt = 4'h0;
			ack_nxt = 1'b0;
			case (lk_st_r)
				BSC_CTRL: begin
					if (!ack_r) begin
						lk_st_nxt = BSC_IGNORE;
					end else if (sh_r[0]) begin
						rd_reg_nxt = (sh_r[7:4] == BSC_OP_REG);
						tx_nxt = (sh_r[7:4] == BSC_OP_REG) ? stat_r : mem_q;
						if (sh_r[7:4] != BSC_OP_REG) begin
							ptr_nxt = ptr_r + AW'(1);
						end
						lk_st_nxt = BSC_READ;
					end else begin
						lk_st_nxt = (sh_r[7:4] == BSC_OP_REG) ? BSC_REG_ADDR : BSC_ADDR_HI;
					end
				end
				BSC_ADDR_HI: begin
					ptr_nxt = {sh_r[AW-9:0], ptr_r[7:0]};
					lk_st_nxt = BSC_ADDR_LO;
				end
				BSC_ADDR_LO: begin
					ptr_nxt = {ptr_r[AW-1:8], sh_r};
					lk_st_nxt = BSC_DATA_W;
				end
				BSC_DATA_W: begin
					if (ack_r) begin
						wr_en = 1'b1;
						ptr_nxt = ptr_r + AW'(1);
					end else begin
						lk_st_nxt = BSC_IGNORE;
					end
				end
				BSC_REG_ADDR: begin
					rsel_nxt = sh_r;
					lk_st_nxt = ack_r ? BSC_REG_DATA : BSC_IGNORE;
				end
				BSC_REG_DATA: begin
					if (ack_r) begin
						if (rsel_r == BSC_REG_STATUS) begin
							stat_nxt = sh_r;
							wc_tgl_nxt = ~wc_tgl_r;
						end else if (sh_r == BSC_CMD_STORE) begin
							store_tgl_nxt = ~store_tgl_r;
						end else begin
							recall_tgl_nxt = ~recall_tgl_r;
						end
					end
					lk_st_nxt = BSC_IGNORE;
				end
				BSC_READ: begin
					if (sda_in) begin
						lk_st_nxt = BSC_IGNORE;
					end else begin
						tx_nxt = rd_reg_r ? stat_r : mem_q;
						if (!rd_reg_r) begin
							ptr_nxt = ptr_r + AW'(1);
						end
					end
				end
				default: lk_st_nxt = BSC_IGNORE;
			endcase
		end
	end

	// strap and reset levels pass two link flops before use
	always_ff @(posedge scl_link) begin
		lrst_s_r <= {lrst_s_r[0], rst_n};
		csh_s_r <= {csh_s_r[0], chip_select_pin_high};
		csl_s_r <= {csl_s_r[0], chip_select_pin_low};
		if (!lrst_s_r[1]) begin
			lk_st_r <= BSC_IGNORE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			ack_r <= 1'b0;
			ptr_r <= '0;
			tx_r <= 8'h00;
			rsel_r <= 8'h00;
			stat_r <= BSC_STATUS_RST;
			rd_reg_r <= 1'b0;
			seen_r <= 1'b0;
			store_tgl_r <= 1'b0;
			recall_tgl_r <= 1'b0;
			wc_tgl_r <= 1'b0;
		end else begin
			lk_st_r <= lk_st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			ack_r <= ack_nxt;
			ptr_r <= ptr_nxt;
			tx_r <= tx_nxt;
			rsel_r <= rsel_nxt;
			stat_r <= stat_nxt;
			rd_reg_r <= rd_reg_nxt;
			seen_r <= seen_nxt;
			store_tgl_r <= store_tgl_nxt;
			recall_tgl_r <= recall_tgl_nxt;
			wc_tgl_r <= wc_tgl_nxt;
		end
	end

	// array storage, no reset so it maps to plain ram
	always_ff @(posedge scl_link) begin
		if (wr_en) begin
			mem[ptr_r] <= sh_r;
		end
	end

	// pin drive changes only on the falling edge, while scl is low
	always_comb begin
		drv_nxt = 1'b0;
		if (seen_r != gen_r) begin
			drv_nxt = 1'b0;
		end else if (lk_st_r == BSC_READ && cnt_r != BSC_ACK_BIT) begin
			drv_nxt = ~tx_r[3'(BSC_LAST_BIT - cnt_r)];
		end else if (cnt_r == BSC_ACK_BIT) begin
			drv_nxt = ack_r;
		end
	end

	always_ff @(negedge scl_link) begin
		if (!lrst_s_r[1]) begin
			drv_r <= 1'b0;
		end else begin
			drv_r <= drv_nxt;
		end
	end

endmodule // bsc_client
`default_nettype wire

// ==== dv/bsc_client_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsc_client_properties
	import bsc_pkg::*;
#(
	parameter int AW = 9,
	parameter int TWC_CYC = BSC_TWC_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl_link,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic chip_select_pin_high,
	input wire logic chip_select_pin_low,
	input wire logic store_pulse,
	input wire logic recall_pulse,
	input wire logic status_busy,
	input wire logic bus_live
);
	int busy_cnt_r;
	int busy_cnt_nxt;
	// run length of busy, so its exact span can be judged
	always_comb begin
		busy_cnt_nxt = status_busy ? busy_cnt_r + 1 : 0;
	end
	always_ff @(posedge clk_sys) begin
		busy_cnt_r <= rst_n ? busy_cnt_nxt : 0;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	start_seen_a: assert property (scl_link && $fell(sda_in) |-> ##[1:6] bus_live)
		else $error("start not detected");
	stop_seen_a: assert property (scl_link && $rose(sda_in) |-> ##[1:6] !bus_live)
		else $error("stop not detected");
	drive_stable_a: assert property (scl_link && $past(scl_link) && bus_live && $past(bus_live)
		|-> $stable(sda_oe)) else $error("pin moved while clock high");
	idle_quiet_a: assert property (!bus_live && !$past(bus_live) |-> !sda_oe)
		else $error("pin driven on idle bus");
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("pin output not low");
	store_once_a: assert property (store_pulse |=> !store_pulse)
		else $error("store pulse too long");
	recall_once_a: assert property (recall_pulse |=> !recall_pulse)
		else $error("recall pulse too long");
	cmd_live_a: assert property (store_pulse || recall_pulse |-> bus_live)
		else $error("command outside transfer");
	busy_span_a: assert property ($fell(status_busy) |-> busy_cnt_r == TWC_CYC)
		else $error("busy span wrong");
	cover property (store_pulse);
	cover property (recall_pulse);
	cover property ($rose(status_busy));
	cover property ($rose(sda_oe));
endmodule // bsc_client_properties
bind bsc_client bsc_client_properties #(.AW(AW), .TWC_CYC(TWC_CYC)) u_props (
	.clk_sys(clk_sys), .rst_n(rst_n), .scl_link(scl_link), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pin_high(chip_select_pin_high),
	.chip_select_pin_low(chip_select_pin_low), .store_pulse(store_pulse),
	.recall_pulse(recall_pulse), .status_busy(status_busy), .bus_live(bus_live));
`default_nettype wire

// ==== dv/bsc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsc_host (
	output var logic scl,
	output var logic sda_drv,
	input wire logic sda
);
	localparam int HALF = 24;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// sample mid-way through the high phase, data already settled
	task automatic pulse(output logic s);
		#HALF scl = 1'b1;
		#(HALF / 2) s = sda;
		#(HALF / 2) scl = 1'b0;
	endtask
	// clocks with data high, no bus condition, ends high
	task automatic idle(input int n);
		repeat (n) begin
			#HALF scl = 1'b0;
			#HALF scl = 1'b1;
		end
	endtask
	// start from released lines, held past five system cycles
	task automatic start();
		sda_drv = 1'b1;
		#HALF scl = 1'b1;
		#HALF sda_drv = 1'b0;
		#60 scl = 1'b0;
	endtask
	// msb first, data moves while clock low, ninth pulse answers
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_drv = b[i];
			pulse(s);
		end
		sda_drv = 1'b1;
		pulse(ack);
	endtask
	// host answers each byte, high on the last
	task automatic recv(input logic last, output logic [7:0] b);
		logic s;
		sda_drv = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			pulse(s);
			b[i] = s;
		end
		sda_drv = last;
		pulse(s);
		sda_drv = 1'b1;
	endtask
	// stop closes the transfer, then the bus rests
	task automatic stop();
		sda_drv = 1'b0;
		#HALF scl = 1'b1;
		#HALF sda_drv = 1'b1;
		#200;
	endtask
endmodule // bsc_host
`default_nettype wire

// ==== dv/bsc_client_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsc_client_test;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cs_hi = 1'b0;
	logic cs_lo = 1'b0;
	logic scl_link, host_sda, sda_in, sda_out, sda_oe;
	logic store_pulse, recall_pulse, status_busy, bus_live;
	int miscompares = 0;
	int n_compared = 0;
	int n_st = 0;
	int n_rc = 0;
	always #5 clk_sys = ~clk_sys;
	// open drain wire with pull-up
	assign sda_in = host_sda & (sda_oe ? sda_out : 1'b1);
	bsc_client #(.TWC_CYC(20)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_link(scl_link),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pin_high(cs_hi),
		.chip_select_pin_low(cs_lo), .store_pulse(store_pulse), .recall_pulse(recall_pulse),
		.status_busy(status_busy), .bus_live(bus_live));
	bsc_host u_host (.scl(scl_link), .sda_drv(host_sda), .sda(sda_in));
	// command pulse tallies
	always @(posedge clk_sys) begin
		n_st <= n_st + ((store_pulse === 1'b1) ? 1 : 0);
		n_rc <= n_rc + ((recall_pulse === 1'b1) ? 1 : 0);
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] b, input logic nack);
		logic a;
		u_host.send(b, a);
		chk({7'h00, a}, {7'h00, nack});
	endtask
	// array write header, pointer to 010h
	task automatic set_ptr();
		u_host.start();
		wr(8'ha0, 1'b0);
		wr(8'h00, 1'b0);
		wr(8'h10, 1'b0);
	endtask
	task automatic t_write();
		set_ptr();
		wr(8'h5a, 1'b0);
		wr(8'hc3, 1'b0);
		u_host.stop();
	endtask
	task automatic t_read();
		logic [7:0] d;
		set_ptr();
		u_host.start();
		wr(8'ha1, 1'b0);
		u_host.recv(1'b0, d);
		chk(d, 8'h5a);
		u_host.recv(1'b1, d);
		chk(d, 8'hc3);
		// pin flop moves on this scl fall, look once it has settled
		@(negedge clk_sys);
		chk({7'h00, sda_oe}, 8'h00);
		u_host.stop();
	endtask
	// one protect step guards only the top eight bytes
	task automatic t_partial();
		logic [7:0] d;
		u_host.start();
		wr(8'h30, 1'b0);
		wr(8'h00, 1'b0);
		wr(8'h04, 1'b0);
		u_host.stop();
		u_host.start();
		wr(8'ha0, 1'b0);
		wr(8'h01, 1'b0);
		wr(8'hf7, 1'b0);
		wr(8'h11, 1'b0);
		wr(8'h22, 1'b1);
		wr(8'h33, 1'b1);
		u_host.stop();
		u_host.start();
		wr(8'ha0, 1'b0);
		wr(8'h01, 1'b0);
		wr(8'hf7, 1'b0);
		u_host.start();
		wr(8'ha1, 1'b0);
		u_host.recv(1'b1, d);
		chk(d, 8'h11);
		u_host.stop();
	endtask
	// whole array protected afterwards
	task automatic t_status();
		logic [7:0] d;
		u_host.start();
		wr(8'h30, 1'b0);
		wr(8'h00, 1'b0);
		wr(8'h1c, 1'b0);
		chk({7'h00, bus_live}, 8'h01);
		repeat (6) @(negedge clk_sys);
		chk({7'h00, status_busy}, 8'h01);
		u_host.stop();
		repeat (30) @(negedge clk_sys);
		chk({7'h00, status_busy}, 8'h00);
		chk({7'h00, bus_live}, 8'h00);
		// register read hands back the status byte
		u_host.start();
		wr(8'h31, 1'b0);
		u_host.recv(1'b1, d);
		chk(d, 8'h1c);
		u_host.stop();
	endtask
	task automatic t_protect();
		logic [7:0] d;
		set_ptr();
		wr(8'h77, 1'b1);
		wr(8'h88, 1'b1);
		u_host.stop();
		u_host.start();
		wr(8'ha1, 1'b0);
		u_host.recv(1'b1, d);
		chk(d, 8'h5a);
		u_host.stop();
	endtask
	task automatic t_cmds();
		logic [7:0] ra [4] = '{8'h55, 8'h55, 8'h55, 8'h22};
		logic [7:0] da [4] = '{8'h33, 8'hdd, 8'h44, 8'h00};
		logic [3:0] na = 4'h8;
		logic [3:0] nd = 4'hc;
		int s;
		int r;
		for (int i = 0; i < 4; i++) begin
			s = n_st;
			r = n_rc;
			u_host.start();
			wr(8'h30, 1'b0);
			wr(ra[i], na[i]);
			wr(da[i], nd[i]);
			u_host.stop();
			chk(8'(n_st - s), {7'h00, i == 0});
			chk(8'(n_rc - r), {7'h00, i == 1});
		end
	endtask
	// strap high, then matching, wrong strap, set zero bit
	task automatic t_select();
		logic [7:0] cb [3] = '{8'ha8, 8'ha0, 8'haa};
		@(negedge clk_sys) cs_hi <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			u_host.start();
			wr(cb[i], i != 0);
			u_host.stop();
		end
		// low strap raised: only a byte with bit 2 set answers
		@(negedge clk_sys) cs_lo <= 1'b1;
		u_host.start();
		wr(8'hac, 1'b0);
		u_host.stop();
		u_host.start();
		wr(8'ha8, 1'b1);
		u_host.stop();
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// link flops need scl edges inside reset, so it spans them
	initial begin
		u_host.idle(4);
		@(negedge clk_sys) rst_n <= 1'b1;
		u_host.idle(2);
		t_write();
		t_read();
		t_partial();
		t_status();
		t_protect();
		t_cmds();
		t_select();
		wrap_up();
	end
	// run needs about 30 us, so a hang shows well before this
	initial begin
		#500000;
		miscompares++;
		wrap_up();
	end
endmodule // bsc_client_test
`default_nettype wire
